// [csp_pkg.sv]
// Constants shared by the two-wire control slave port and its helpers.
// Assumes a single device clock; all users reference names as csp_pkg::name.
package csp_pkg;

  // ****************************************************************
  // Addressing
  // ****************************************************************
  localparam logic [6:0] SLAVE_ADDR   = 7'h18; // Own 7-bit slave address
  localparam logic [6:0] GCALL_ADDR   = 7'h00; // General call address
  localparam logic [3:0] BYTE_BITS    = 4'h8;  // Bits per byte on the wire
  localparam logic [3:0] CNT_ZERO     = 4'h0;
  localparam logic [3:0] CNT_ONE      = 4'h1;

  // ****************************************************************
  // Register file
  // ****************************************************************
  localparam int         NUM_REGS       = 128;   // Page 0 registers
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] BUS_ERR_CTRL   = 8'h6b; // Bus error detect control
  localparam int         ERR_STATUS_BIT = 0;     // Detector status, sticky
  localparam int         ERR_DIS_BIT    = 2;     // Detector disable

  // ****************************************************************
  // Transaction state, one-hot
  // ****************************************************************
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_RX     = 6'h02,
    ST_RX_ACK = 6'h04,
    ST_TX     = 6'h08,
    ST_TX_ACK = 6'h10,
    ST_SKIP   = 6'h20
  } csp_state_t;

  // Byte role inside a transaction
  typedef enum logic [2:0] {
    PH_ADDR = 3'h1,
    PH_PTR  = 3'h2,
    PH_DATA = 3'h4
  } csp_phase_t;

endpackage : csp_pkg

// [csp_sync.sv]
// Two-stage synchroniser for the bus clock and data pins.
// Assumes inputs arrive asynchronously to ref_clk_in.
`timescale 1ns/10ps
module csp_sync (
  input  wire logic       ref_clk_in,
  input  wire logic       resetn_in,
  input  wire logic [1:0] pins_in,
  output logic      [1:0] pins_out
);

  logic [1:0] meta_q;
  logic [1:0] sync_q;

  // ****************************************************************
  // Two flops; the first is read only by the second
  // ****************************************************************
  // Reset to high: an idle bus has both lines pulled up
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
    end else begin
      meta_q <= pins_in;
      sync_q <= meta_q;
    end
  end

  assign pins_out = sync_q;

endmodule : csp_sync

// [csp_regfile.sv]
// Page 0 register array behind the control slave port.
// Assumes one write strobe per byte from the port logic, same clock.
`timescale 1ns/10ps
module csp_regfile (
  input  wire logic       ref_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       wr_en_in,
  input  wire logic [7:0] wr_addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic [7:0] rd_addr_in,
  input  wire logic       err_set_in,
  output logic      [7:0] rd_data_out,
  output logic            err_status_out,
  output logic            det_disable_out
);

  logic [7:0] mem_q [csp_pkg::NUM_REGS];
  logic       err_q;
  logic       err_d;
  logic       ctrl_wr;

  // Only the low page exists; higher pointers read zero
  function automatic logic in_page(input logic [7:0] a);
    in_page = (a[7] == 1'b0);
  endfunction : in_page

  assign ctrl_wr = wr_en_in && (wr_addr_in == csp_pkg::BUS_ERR_CTRL);

  // ****************************************************************
  // Sticky error status
  // ****************************************************************
  // Writing one clears it; a new error in the same cycle wins
  always_comb begin
    err_d = err_q;
    if (ctrl_wr && wr_data_in[csp_pkg::ERR_STATUS_BIT]) begin
      err_d = 1'b0;
    end
    if (err_set_in) begin
      err_d = 1'b1; // R16
    end
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Reset to zero leaves the error detector enabled
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      err_q <= 1'b0;
      for (int i = 0; i < csp_pkg::NUM_REGS; i++) begin
        mem_q[i] <= csp_pkg::REG_RESET; // R15
      end
    end else begin
      err_q <= err_d;
      if (wr_en_in && in_page(wr_addr_in)) begin
        mem_q[wr_addr_in[6:0]] <= wr_data_in; // R17
      end
    end
  end

  // Read mux; the status bit is the live sticky flag
  always_comb begin
    rd_data_out = 8'h00;
    if (in_page(rd_addr_in)) begin
      rd_data_out = mem_q[rd_addr_in[6:0]];
    end
    if (rd_addr_in == csp_pkg::BUS_ERR_CTRL) begin
      rd_data_out[csp_pkg::ERR_STATUS_BIT] = err_q; // R16
    end
  end

  assign err_status_out  = err_q;
  assign det_disable_out = mem_q[csp_pkg::BUS_ERR_CTRL[6:0]][csp_pkg::ERR_DIS_BIT];

endmodule : csp_regfile

// [csp_ctrl_port.sv]
// Two-wire control slave port of an audio codec, with page 0 registers.
// Assumes the bus master drives SCL; SCL and SDA reach us asynchronously.
//
// What this block does
// (R1) Host pulses active-low reset at least 10 ns before register access.
// (R2) Decode 7-bit addresses; answer only own address or general call.
// (R3) Work at standard-mode and fast-mode bus rates.
// (R4) Never act as master or drive the clock line.
// (R5) Bytes of eight bits; data changes while clock low, sampled on high.
// (R6) Data falling with clock high is start; rising is stop.
// (R7) Master sends address byte with direction bit after start.
// (R8) Pull data low in the ninth clock to acknowledge each received byte.
// (R9) Reading master acknowledges each byte and supplies that clock.
// (R10) Released data in the acknowledge clock means not-acknowledge.
// (R11) Start during an active transaction restarts address decoding; a misplaced start inside a byte, detector on, goes to idle instead.
// (R12) Acknowledge the general call address byte 00h.
// (R13) Consecutive written bytes go to consecutive registers.
// (R14) Master acknowledge on read makes us send the next register.
// (R15) Bus error detector on from reset; error ends the transaction.
// (R16) Detector status readable in bit 0 of register 107.
// (R17) Bit 2 of register 107 disables the detector.
// (R18) Only pull lines low or release them, never drive high.
// (R19) Stop returns to idle with lines released.
// (R20) First data byte of a write loads the register pointer.
`timescale 1ns/10ps
module csp_ctrl_port (
  input  wire logic       ref_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic            wr_strobe_out,
  output logic      [7:0] wr_addr_out,
  output logic      [7:0] wr_data_out,
  output logic            bus_error_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  csp_pkg::csp_state_t state_q, state_d;
  csp_pkg::csp_phase_t phase_q, phase_d;
  logic [3:0] cnt_q,    cnt_d;
  logic [7:0] sh_q,     sh_d;
  logic [7:0] tx_q,     tx_d;
  logic [7:0] ptr_q,    ptr_d;
  logic       rw_q,     rw_d;
  logic       gcall_q,  gcall_d;
  logic       mack_q,   mack_d;
  logic       oe_q,     oe_d;
  logic       wr_q,     wr_d;
  logic [7:0] wa_q,     wa_d;
  logic [7:0] wd_q,     wd_d;
  logic       err_q,    err_d;
  logic       low_q;
  logic       scl_p_q,  sda_p_q;
  logic [1:0] pins_s;
  logic       scl_s,    sda_s;
  logic       scl_rise, scl_fall;
  logic       start_ev, stop_ev;
  logic       mid_byte, det_dis;
  logic       err_stat;
  logic [7:0] rd_data;

  // Address byte decode, used for own address and general call
  function automatic logic addr_hit(input logic [7:0] b);
    addr_hit = (b[7:1] == csp_pkg::SLAVE_ADDR) || (b[7:1] == csp_pkg::GCALL_ADDR);
  endfunction : addr_hit

  // ****************************************************************
  // Pin sampling and bus events
  // ****************************************************************
  csp_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .pins_in    ({scl_in, sda_in}),
    .pins_out   (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Edges are judged on synchronised copies only
  assign scl_rise = scl_s && !scl_p_q; // R3 R5
  assign scl_fall = !scl_s && scl_p_q;
  assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s; // R6
  assign stop_ev  = scl_s && scl_p_q && !sda_p_q && sda_s; // R6

  // A start or stop between the second and the eighth clock rise of a byte is misplaced; the clock rise
  // that comes before every legal start or stop in ST_RX or ST_TX leaves the counter at one
  assign mid_byte = ((state_q == csp_pkg::ST_RX) || (state_q == csp_pkg::ST_TX))
                    && (cnt_q != csp_pkg::CNT_ZERO) && (cnt_q != csp_pkg::CNT_ONE)
                    && (cnt_q != csp_pkg::BYTE_BITS);

  // ****************************************************************
  // Register array
  // ****************************************************************
  csp_regfile u_regs (
    .ref_clk_in      (ref_clk_in),
    .resetn_in       (resetn_in),
    .wr_en_in        (wr_q),
    .wr_addr_in      (wa_q),
    .wr_data_in      (wd_q),
    .rd_addr_in      (ptr_q),
    .err_set_in      (err_q),
    .rd_data_out     (rd_data),
    .err_status_out  (err_stat),
    .det_disable_out (det_dis)
  );

  // ****************************************************************
  // Transaction sequencer, next state
  // ****************************************************************
  // Start and stop override every bit-level action in the same cycle
  always_comb begin
    state_d = state_q;
    phase_d = phase_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    tx_d    = tx_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    gcall_d = gcall_q;
    mack_d  = mack_q;
    oe_d    = oe_q;
    wr_d    = 1'b0;
    wa_d    = wa_q;
    wd_d    = wd_q;
    err_d   = 1'b0;
    if (stop_ev) begin
      if (mid_byte && !det_dis) begin
        err_d = 1'b1; // R15
      end
      state_d = csp_pkg::ST_IDLE; // R19
      oe_d    = 1'b0;
    end else if (start_ev) begin
      oe_d = 1'b0;
      if (mid_byte && !det_dis) begin
        err_d   = 1'b1; // R15
        state_d = csp_pkg::ST_IDLE;
      end else begin
        state_d = csp_pkg::ST_RX; // R11
        phase_d = csp_pkg::PH_ADDR;
        cnt_d   = csp_pkg::CNT_ZERO;
        rw_d    = 1'b0;
        gcall_d = 1'b0;
      end
    end else begin
      case (state_q)
        csp_pkg::ST_IDLE: begin
          oe_d = 1'b0;
        end
        csp_pkg::ST_RX: begin
          if (scl_rise && (cnt_q != csp_pkg::BYTE_BITS)) begin
            sh_d  = {sh_q[6:0], sda_s}; // R5
            cnt_d = cnt_q + csp_pkg::CNT_ONE;
          end else if (scl_fall && (cnt_q == csp_pkg::BYTE_BITS)) begin
            cnt_d   = csp_pkg::CNT_ZERO;
            state_d = csp_pkg::ST_RX_ACK;
            oe_d    = 1'b1; // R8
            case (phase_q)
              csp_pkg::PH_ADDR: begin
                if (addr_hit(sh_q)) begin // R2
                  rw_d    = sh_q[0];
                  gcall_d = (sh_q[7:1] == csp_pkg::GCALL_ADDR); // R12
                  phase_d = csp_pkg::PH_PTR;
                end else begin
                  state_d = csp_pkg::ST_SKIP; // R10
                  oe_d    = 1'b0;
                end
              end
              csp_pkg::PH_PTR: begin
                if (!gcall_q) begin
                  ptr_d   = sh_q; // R20
                  phase_d = csp_pkg::PH_DATA;
                end
              end
              csp_pkg::PH_DATA: begin
                wr_d  = 1'b1; // R13
                wa_d  = ptr_q;
                wd_d  = sh_q;
                ptr_d = ptr_q + 8'h01;
              end
              default: begin
                phase_d = csp_pkg::PH_ADDR;
              end
            endcase
          end
        end
        csp_pkg::ST_RX_ACK: begin
          // Acknowledge held through the ninth clock; on its fall released for a write, first data bit driven for a read
          if (scl_fall) begin
            if (rw_q) begin
              tx_d    = rd_data; // R14
              ptr_d   = ptr_q + 8'h01;
              oe_d    = !rd_data[7];
              state_d = csp_pkg::ST_TX;
            end else begin
              oe_d    = 1'b0;
              state_d = csp_pkg::ST_RX;
            end
          end
        end
        csp_pkg::ST_TX: begin
          if (scl_rise && (cnt_q != csp_pkg::BYTE_BITS)) begin
            cnt_d = cnt_q + csp_pkg::CNT_ONE;
          end else if (scl_fall) begin
            if (cnt_q == csp_pkg::BYTE_BITS) begin
              cnt_d   = csp_pkg::CNT_ZERO;
              oe_d    = 1'b0; // R9
              state_d = csp_pkg::ST_TX_ACK;
            end else if (cnt_q != csp_pkg::CNT_ZERO) begin
              tx_d = {tx_q[6:0], 1'b0};
              oe_d = !tx_q[6]; // R5
            end
          end
        end
        csp_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            mack_d = !sda_s; // R9
          end else if (scl_fall) begin
            if (mack_q) begin
              tx_d    = rd_data; // R14
              ptr_d   = ptr_q + 8'h01;
              oe_d    = !rd_data[7];
              state_d = csp_pkg::ST_TX;
            end else begin
              state_d = csp_pkg::ST_SKIP; // R10
            end
          end
        end
        csp_pkg::ST_SKIP: begin
          oe_d = 1'b0; // R10
        end
        default: begin
          state_d = csp_pkg::ST_IDLE;
          oe_d    = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Transaction sequencer, registers
  // ****************************************************************
  // Pointer survives stop so a later read can follow a pointer write
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= csp_pkg::ST_IDLE;
      phase_q <= csp_pkg::PH_ADDR;
      cnt_q   <= csp_pkg::CNT_ZERO;
      sh_q    <= 8'h00;
      tx_q    <= 8'h00;
      ptr_q   <= csp_pkg::PTR_RESET;
      rw_q    <= 1'b0;
      gcall_q <= 1'b0;
      mack_q  <= 1'b0;
      oe_q    <= 1'b0;
      wr_q    <= 1'b0;
      wa_q    <= 8'h00;
      wd_q    <= 8'h00;
      err_q   <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      low_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      tx_q    <= tx_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      gcall_q <= gcall_d;
      mack_q  <= mack_d;
      oe_q    <= oe_d;
      wr_q    <= wr_d;
      wa_q    <= wa_d;
      wd_q    <= wd_d;
      err_q   <= err_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      low_q   <= 1'b0; // R18
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Data pin only ever pulls low; there is no clock pin output at all
  assign sda_out       = low_q;  // R18
  assign sda_oe_out    = oe_q;   // R4
  assign wr_strobe_out = wr_q;
  assign wr_addr_out   = wa_q;
  assign wr_data_out   = wd_q;
  assign bus_error_out = err_stat;

endmodule : csp_ctrl_port

// [csp_monitor.sv]
// Checker of the control slave port; it sees the port pins only.
// Assumes bus clock phases of at least four ref clocks.
`timescale 1ns/10ps
module csp_monitor (
  input wire logic       ref_clk_in,
  input wire logic       resetn_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic       wr_strobe_out,
  input wire logic [7:0] wr_addr_out,
  input wire logic [7:0] wr_data_out,
  input wire logic       bus_error_out
);
  logic [1:0] scl_q;
  logic [1:0] sda_q;
  logic [7:0] last_q;
  logic       seen_q;
  logic [2:0] ev_q;
  logic [2:0] clr_q;
  logic       start_c;
  logic       stop_c;
  logic       clr_c;
  // ****************************************************************
  // Pin view and helper windows
  // ****************************************************************
  assign start_c = scl_q[1] & sda_q[1] & ~sda_q[0];
  assign stop_c  = scl_q[1] & ~sda_q[1] & sda_q[0];
  assign clr_c   = wr_strobe_out & (wr_addr_out == csp_pkg::BUS_ERR_CTRL) & wr_data_out[0];
  // Windows are short so a flag that moves without its cause is caught
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_q  <= 2'h3;
      sda_q  <= 2'h3;
      last_q <= 8'h00;
      seen_q <= 1'b0;
      ev_q   <= 3'h0;
      clr_q  <= 3'h0;
    end else begin
      scl_q  <= {scl_q[0], scl_in};
      sda_q  <= {sda_q[0], sda_in};
      ev_q   <= (start_c | stop_c) ? 3'h7 : ev_q - {2'h0, |ev_q};
      clr_q  <= clr_c ? 3'h7 : clr_q - {2'h0, |clr_q};
      seen_q <= wr_strobe_out | (seen_q & ~start_c);
      last_q <= wr_strobe_out ? wr_addr_out : last_q;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  property p_no_high; !sda_out; endproperty
  a_no_high: assert property (p_no_high) else $error("data driven high");
  property p_oe_scl_low; $changed(sda_oe_out) |-> !$past(scl_q[1]); endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved, clock high");
  property p_ack_hold; $rose(sda_oe_out) |=> sda_oe_out [*5]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("pull too short");
  property p_strobe_ack; wr_strobe_out |-> $rose(sda_oe_out); endproperty
  a_strobe_ack: assert property (p_strobe_ack) else $error("write without ack");
  property p_autoinc; wr_strobe_out && seen_q |-> wr_addr_out == last_q + 8'h01; endproperty
  a_autoinc: assert property (p_autoinc) else $error("address not next");
  property p_stop_idle; stop_c |-> ##[0:3] !sda_oe_out ##1 !sda_oe_out [*3]; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("held after stop");
  property p_err_cause; $rose(bus_error_out) |-> ev_q != 3'h0; endproperty
  a_err_cause: assert property (p_err_cause) else $error("error without edge");
  property p_err_free; $rose(bus_error_out) |-> !sda_oe_out [*4]; endproperty
  a_err_free: assert property (p_err_free) else $error("held after error");
  property p_err_sticky; $fell(bus_error_out) |-> clr_q != 3'h0 || clr_c; endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("status lost");
  c_write: cover property (wr_strobe_out);
  c_error: cover property ($rose(bus_error_out));
  c_drive: cover property ($rose(sda_oe_out));
endmodule : csp_monitor
bind csp_ctrl_port csp_monitor csp_monitor_inst (.*);

// [csp_host.sv]
// Two-wire bus master model on the host side of the port.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/10ps
module csp_host (
  input  wire logic ref_clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // ****************************************************************
  // Bus cycles, phases of four ref clocks
  // ****************************************************************
  // Clock stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : wait_clk
  // Data moves mid-low, sampled at the end of the high phase
  task automatic xfer_bit(input logic b, output logic r);
    wait_clk(2);
    sda_low_out <= !b;
    wait_clk(2);
    scl_out <= 1'b1;
    wait_clk(4);
    r = sda_in;
    scl_out <= 1'b0;
  endtask : xfer_bit
  // Works from idle and as a repeated start
  task automatic start_cond();
    wait_clk(2);
    sda_low_out <= 1'b0;
    wait_clk(2);
    scl_out <= 1'b1;
    wait_clk(4);
    sda_low_out <= 1'b1;
    wait_clk(4);
    scl_out <= 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    wait_clk(2);
    sda_low_out <= 1'b1;
    wait_clk(2);
    scl_out <= 1'b1;
    wait_clk(4);
    sda_low_out <= 1'b0;
    wait_clk(4);
  endtask : stop_cond
  task automatic write_byte(input logic [7:0] d, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
    xfer_bit(1'b1, nack);
  endtask : write_byte
  // Last byte is refused by leaving data released
  task automatic read_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(last, r);
  endtask : read_byte
endmodule : csp_host

// [testbench.sv]
// Bench of the control slave port: table cases, then edge cases.
// Assumes csp_pkg, csp_host and the bound checker compile first.
`timescale 1ns/10ps
module testbench;
  typedef struct {logic [7:0] p; logic [7:0] d0; logic [7:0] d1;} csp_row_t;
  localparam logic [7:0] WA = {csp_pkg::SLAVE_ADDR, 1'b0};
  localparam logic [7:0] RA = {csp_pkg::SLAVE_ADDR, 1'b1};
  logic       ref_clk_in;
  logic       resetn_in;
  logic       scl_w;
  logic       sda_low;
  logic       sda_out;
  logic       sda_oe_out;
  logic       wr_strobe_out;
  logic [7:0] wr_addr_out;
  logic [7:0] wr_data_out;
  logic       bus_error_out;
  logic [7:0] a;
  logic [7:0] b;
  logic       n;
  logic [7:0] got_a[$];
  logic [7:0] got_d[$];
  int         mismatches;
  int         total_checks;
  wire        sda_w;
  csp_row_t   rows[3] = '{'{8'h10, 8'h55, 8'haa}, '{8'h7e, 8'h01, 8'hfe}, '{8'h00, 8'hff, 8'h00}};
  // ****************************************************************
  // Wiring and helpers
  // ****************************************************************
  // Pull-up: a driven high reads the same as the pull-up, so only the checker sees it
  assign sda_w = sda_low ? 1'b0 : (sda_oe_out ? sda_out : 1'b1);
  csp_ctrl_port csp_ctrl_port_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .wr_strobe_out(wr_strobe_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
    .bus_error_out(bus_error_out));
  csp_host csp_host_inst (.ref_clk_in(ref_clk_in), .sda_in(sda_w), .scl_out(scl_w),
    .sda_low_out(sda_low));
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  // Strobe lasts one cycle, so it is logged as it passes
  always @(posedge ref_clk_in) begin
    if (wr_strobe_out === 1'b1) begin
      got_a.push_back(wr_addr_out);
      got_d.push_back(wr_data_out);
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic reg_write(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
    csp_host_inst.start_cond();
    csp_host_inst.write_byte(WA, n);
    check(n, 8'h00);
    csp_host_inst.write_byte(p, n);
    csp_host_inst.write_byte(d0, n);
    csp_host_inst.write_byte(d1, n);
    check(n, 8'h00);
    csp_host_inst.stop_cond();
  endtask : reg_write
  task automatic reg_read(input logic [7:0] p);
    csp_host_inst.start_cond();
    csp_host_inst.write_byte(WA, n);
    csp_host_inst.write_byte(p, n);
    csp_host_inst.start_cond();
    csp_host_inst.write_byte(RA, n);
    check(n, 8'h00);
    csp_host_inst.read_byte(1'b0, a);
    csp_host_inst.read_byte(1'b1, b);
    csp_host_inst.stop_cond();
  endtask : reg_read
  // Stop in the middle of a byte
  task automatic abort();
    csp_host_inst.start_cond();
    csp_host_inst.write_byte(WA, n);
    repeat (3) csp_host_inst.xfer_bit(1'b1, n);
    csp_host_inst.stop_cond();
    repeat (4) @(posedge ref_clk_in);
  endtask : abort
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    resetn_in = 1'b0;
    mismatches = 0;
    total_checks = 0;
    repeat (10) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    foreach (rows[i]) begin
      reg_write(rows[i].p, rows[i].d0, rows[i].d1);
      check(got_a.pop_front(), rows[i].p);
      check(got_d.pop_front(), rows[i].d0);
      check(got_a.pop_front(), rows[i].p + 8'h01);
      check(got_d.pop_front(), rows[i].d1);
      reg_read(rows[i].p);
      check(a, rows[i].d0);
      check(b, rows[i].d1);
    end
    csp_host_inst.start_cond();
    csp_host_inst.write_byte(WA ^ 8'h02, n);
    check(n, 8'h01);
    csp_host_inst.write_byte(8'h20, n);
    csp_host_inst.stop_cond();
    csp_host_inst.start_cond();
    csp_host_inst.write_byte(8'h00, n);
    check(n, 8'h00);
    csp_host_inst.stop_cond();
    check(8'(got_a.size()), 8'h00);
    check(bus_error_out, 8'h00);
    abort();
    check(bus_error_out, 8'h01);
    reg_read(csp_pkg::BUS_ERR_CTRL);
    check(a & 8'h01, 8'h01);
    resetn_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    check(bus_error_out, 8'h00);
    check(sda_oe_out, 8'h00);
    resetn_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    reg_read(8'h10);
    check(a, csp_pkg::REG_RESET);
    abort();
    check(bus_error_out, 8'h01);
    got_a.delete();
    reg_write(csp_pkg::BUS_ERR_CTRL, 8'h05, 8'h00);
    check(bus_error_out, 8'h00);
    abort();
    check(bus_error_out, 8'h00);
    reg_read(csp_pkg::BUS_ERR_CTRL);
    check(a, 8'h04);
    end_sim();
  end
  // Run takes about 4,300 ref clocks
  initial begin
    #2000000;
    mismatches++;
    end_sim();
  end
endmodule : testbench
